//--- verilog/card_nand_pkg.sv
// constants, types and carriers for the card and flash strobe steering
// How it works
// - memory modes: read, write onto card memory strobes
// - io mode: memory strobes high, io strobes driven
// - assign bits put card selects on cs4, cs2
// - shared pins carry card signals only during card access
// - slot 0 select timed exactly like cs4
// - read-not-write valid for the whole transfer
// - flash assign bit enables flash on cs3 space
// - cs3 active: strobes go to flash enables
// - flash enables drop when address leaves cs3 space
// - a21 is address latch, a22 command latch
// - reset default: byte select, 16 bit, cs-controlled
// - address picks io, common, attribute or ide mode
// - a22 drives register select except in ide
// - card enables follow byte selects or fixed levels
package card_nand_pkg;

	// address space of chip select 3: 0x4000_0000 to 0x4fff_ffff
	localparam int SPACE_HI = 31;
	localparam int SPACE_LO = 28;
	localparam logic [3:0] FLASH_SPACE = 4'h4;

	// card mode field sits at address bits [23:22]
	localparam int MODE_HI = 23;
	localparam int MODE_LO = 22;
	localparam logic [1:0] MAP_ATTR = 2'h0;
	localparam logic [1:0] MAP_COMMON = 2'h1;
	localparam logic [1:0] MAP_IO = 2'h2;
	localparam logic [1:0] MAP_IDE = 2'h3;

	// flash latch enables and card register select
	localparam int ALE_BIT = 21;
	localparam int CLE_BIT = 22;
	localparam int REG_BIT = 22;

	// static controller defaults after reset
	localparam logic CFG_BYTE_SEL_RST = 1'h1;
	localparam logic CFG_BUS16_RST = 1'h1;
	localparam logic CFG_CS_RW_RST = 1'h1;

	typedef enum logic [1:0] {
		MODE_ATTR = 2'b00,
		MODE_COMMON = 2'b01,
		MODE_IO = 2'b11,
		MODE_IDE = 2'b10
	} card_mode_e;

	// signals from the static memory controller, all active low
	typedef struct packed {
		logic [7:0] cs_n;
		logic rd_n;
		logic wr0_n;
		logic bs1_n;
		logic bs3_n;
		logic lb_n;
		logic ub_n;
	} smc_sig_s;

	// shared and dedicated bus pins, all active low
	typedef struct packed {
		logic cs0_n;
		logic cs2_n;
		logic cs3_n;
		logic cs4_n;
		logic rd_n;
		logic wr0_n;
		logic bs1_n;
		logic bs3_n;
	} pin_s;

	typedef struct packed {
		logic byte_select;
		logic bus16;
		logic cs_rw;
	} smc_cfg_s;

endpackage

//--- verilog/card_nand_steer.sv
// strobe and select steering between static controller, card slots and flash
`timescale 1ns/100ps
module card_nand_steer
	import card_nand_pkg::*;
(
	input wire logic mclk, // system clock, 50 mhz
	input wire logic reset, // synchronous, active high
	input wire smc_sig_s smc_in, // controller strobes and selects
	input wire logic [31:0] xfer_addr, // current transfer address
	input wire logic xfer_read, // transfer direction, 1 read
	input wire logic slot0_assign_bit, // cs4 to card slot 0
	input wire logic slot1_assign_bit, // cs2 to card slot 1
	input wire logic nand_assign_bit, // cs3 to flash logic
	input wire logic [1:0] card_bus16, // per slot: 1 = 16 bit width
	input wire logic cfg_load, // load new controller config
	input wire smc_cfg_s cfg_in, // config to load
	output pin_s pins_r, // steered bus pins
	output logic card_enable_low_r, // card enable 1, active low
	output logic card_enable_high_r, // card enable 2, active low
	output logic card_reg_r, // card register select
	output logic flash_output_enable_r, // flash read enable, low
	output logic flash_write_enable_r, // flash write enable, low
	output logic flash_ale_r, // flash address latch enable
	output logic flash_cle_r, // flash command latch enable
	output card_mode_e card_mode_r, // mode of last card access
	output smc_cfg_s smc_cfg_r // controller config
);

	logic slot0_acc;
	logic slot1_acc;
	logic card_acc;
	logic in_flash_space;
	logic flash_acc;
	logic slot_bus16;
	card_mode_e mode_now;
	pin_s pins_nxt;
	logic ce_low_nxt;
	logic ce_high_nxt;

	// address to mode; all four codes are legal so no default
	function automatic card_mode_e decode_mode(input logic [1:0] f);
		card_mode_e m;
		m = MODE_ATTR;
		unique case (f)
			MAP_ATTR: m = MODE_ATTR;
			MAP_COMMON: m = MODE_COMMON;
			MAP_IO: m = MODE_IO;
			MAP_IDE: m = MODE_IDE;
		endcase
		return m;
	endfunction

	// which slot, if any, this access targets
	assign slot0_acc = slot0_assign_bit & ~smc_in.cs_n[4];
	assign slot1_acc = slot1_assign_bit & ~smc_in.cs_n[2];
	assign card_acc = slot0_acc | slot1_acc;
	assign mode_now = decode_mode(xfer_addr[MODE_HI:MODE_LO]);
	assign slot_bus16 = slot0_acc ? card_bus16[0] : card_bus16[1];

	// flash gated by address as well as select, so enables drop at once
	assign in_flash_space = xfer_addr[SPACE_HI:SPACE_LO] == FLASH_SPACE;
	assign flash_acc = nand_assign_bit & ~smc_in.cs_n[3] & in_flash_space;

	// pin multiplexer
	always_comb begin
		pins_nxt.cs2_n = smc_in.cs_n[2];
		pins_nxt.cs3_n = smc_in.cs_n[3];
		// card select reuses cs4 unchanged, keeps the same timing
		pins_nxt.cs4_n = smc_in.cs_n[4];
		pins_nxt.cs0_n = smc_in.cs_n[0];
		pins_nxt.rd_n = smc_in.rd_n;
		pins_nxt.wr0_n = smc_in.wr0_n;
		pins_nxt.bs1_n = smc_in.bs1_n;
		pins_nxt.bs3_n = smc_in.bs3_n;
		if (card_acc) begin
			// direction comes from the transfer, not from strobes
			pins_nxt.cs0_n = xfer_read;
			unique case (mode_now)
				MODE_ATTR, MODE_COMMON: begin
					pins_nxt.rd_n = smc_in.rd_n;
					pins_nxt.wr0_n = smc_in.wr0_n;
					pins_nxt.bs1_n = 1'h1;
					pins_nxt.bs3_n = 1'h1;
				end
				MODE_IO: begin
					pins_nxt.rd_n = 1'h1;
					pins_nxt.wr0_n = 1'h1;
					pins_nxt.bs1_n = smc_in.rd_n;
					pins_nxt.bs3_n = smc_in.wr0_n;
				end
				MODE_IDE: begin
					pins_nxt.rd_n = 1'h0;
					pins_nxt.wr0_n = 1'h1;
					pins_nxt.bs1_n = smc_in.rd_n;
					pins_nxt.bs3_n = smc_in.wr0_n;
				end
			endcase
		end
	end

	// card enables follow the byte selects in 16 bit; 8 bit forces low enable on, high enable off
	always_comb begin
		ce_low_nxt = 1'h1;
		ce_high_nxt = 1'h1;
		if (card_acc) begin
			ce_low_nxt = slot_bus16 ? smc_in.lb_n : 1'h0;
			ce_high_nxt = slot_bus16 ? smc_in.ub_n : 1'h1;
		end
	end

	// bus pins, one flop stage so every output is registered
	always_ff @(posedge mclk) begin
		if (reset) begin
			pins_r <= '1;
		end else begin
			pins_r <= pins_nxt;
		end
	end

	// card side outputs
	always_ff @(posedge mclk) begin
		if (reset) begin
			card_enable_low_r <= 1'h1;
			card_enable_high_r <= 1'h1;
			card_reg_r <= 1'h1;
			card_mode_r <= MODE_ATTR;
		end else begin
			card_enable_low_r <= ce_low_nxt;
			card_enable_high_r <= ce_high_nxt;
			// ide has no register select; hold it inactive high
			card_reg_r <= (mode_now == MODE_IDE) ? 1'h1 : xfer_addr[REG_BIT];
			if (card_acc) begin
				card_mode_r <= mode_now;
			end
		end
	end

	// flash side outputs
	always_ff @(posedge mclk) begin
		if (reset) begin
			flash_output_enable_r <= 1'h1;
			flash_write_enable_r <= 1'h1;
			flash_ale_r <= 1'h0;
			flash_cle_r <= 1'h0;
		end else begin
			flash_output_enable_r <= flash_acc ? smc_in.rd_n : 1'h1;
			flash_write_enable_r <= flash_acc ? smc_in.wr0_n : 1'h1;
			// latches only move during flash access, else they rest low
			flash_ale_r <= flash_acc & xfer_addr[ALE_BIT];
			flash_cle_r <= flash_acc & xfer_addr[CLE_BIT];
		end
	end

	// controller config; software may reload it after boot
	always_ff @(posedge mclk) begin
		if (reset) begin
			smc_cfg_r.byte_select <= CFG_BYTE_SEL_RST;
			smc_cfg_r.bus16 <= CFG_BUS16_RST;
			smc_cfg_r.cs_rw <= CFG_CS_RW_RST;
		end else if (cfg_load) begin
			smc_cfg_r <= cfg_in;
		end
	end

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	logic mem_acc;
	logic io_acc;
	logic ide_acc;
	assign mem_acc = card_acc && (mode_now == MODE_ATTR || mode_now == MODE_COMMON);
	assign io_acc = card_acc && mode_now == MODE_IO;
	assign ide_acc = card_acc && mode_now == MODE_IDE;

	// the edge that releases reset still loads reset values, so the one-cycle
	// checks below, bar AST_FLASH_DROP and AST_ENABLES_IDLE, skip an antecedent taken while in reset
	AST_MEM_STROBES: assert property (
		!reset && mem_acc |=> pins_r.rd_n == $past(smc_in.rd_n)
			&& pins_r.wr0_n == $past(smc_in.wr0_n)
			&& pins_r.bs1_n && pins_r.bs3_n)
		else $error("memory mode strobes wrong");

	AST_IO_STROBES: assert property (
		!reset && io_acc |=> pins_r.rd_n && pins_r.wr0_n && pins_r.bs1_n == $past(smc_in.rd_n)
			&& pins_r.bs3_n == $past(smc_in.wr0_n))
		else $error("io mode strobes wrong");

	AST_IDE_STROBES: assert property (
		!reset && ide_acc |=> !pins_r.rd_n && pins_r.wr0_n && pins_r.bs1_n == $past(smc_in.rd_n)
			&& pins_r.bs3_n == $past(smc_in.wr0_n))
		else $error("ide mode strobes wrong");

	AST_SLOT_SELECTS: assert property (
		!reset |=> pins_r.cs4_n == $past(smc_in.cs_n[4]) && pins_r.cs2_n == $past(smc_in.cs_n[2]))
		else $error("slot select not timed like its chip select");

	AST_RNW_ON_CS0: assert property (
		!reset && card_acc |=> pins_r.cs0_n == $past(xfer_read))
		else $error("read-not-write not from transfer direction");

	AST_RNW_HELD: assert property (
		!reset && card_acc ##1 card_acc && $stable(xfer_read) |=> $stable(pins_r.cs0_n))
		else $error("read-not-write not held through transfer");

	AST_PASSTHROUGH: assert property (
		!reset && !card_acc |=> pins_r.cs0_n == $past(smc_in.cs_n[0])
			&& pins_r.rd_n == $past(smc_in.rd_n)
			&& pins_r.bs1_n == $past(smc_in.bs1_n) && pins_r.bs3_n == $past(smc_in.bs3_n))
		else $error("shared pin modified outside card access");

	AST_FLASH_STROBES: assert property (
		!reset && flash_acc |=> flash_output_enable_r == $past(smc_in.rd_n)
			&& flash_write_enable_r == $past(smc_in.wr0_n))
		else $error("flash enables do not follow strobes");

	AST_FLASH_DROP: assert property (
		!in_flash_space || !nand_assign_bit |=> flash_output_enable_r && flash_write_enable_r)
		else $error("flash enable outside cs3 space");

	AST_FLASH_LATCH: assert property (
		!reset && flash_acc |=> flash_ale_r == $past(xfer_addr[ALE_BIT])
			&& flash_cle_r == $past(xfer_addr[CLE_BIT]))
		else $error("flash latch enables wrong");

	AST_REG_SELECT: assert property (
		!reset && mode_now != MODE_IDE |=> card_reg_r == $past(xfer_addr[REG_BIT]))
		else $error("register select not from a22");

	AST_CARD_ENABLES: assert property (
		!reset && card_acc && !slot_bus16 |=> !card_enable_low_r && card_enable_high_r)
		else $error("8 bit card enables wrong");

	AST_ENABLES_IDLE: assert property (
		!card_acc |=> card_enable_low_r && card_enable_high_r)
		else $error("card enables active without card access");

	AST_CFG_RESET: assert property (
		@(posedge mclk) disable iff (1'b0)
		reset ##1 !cfg_load |-> smc_cfg_r == {CFG_BYTE_SEL_RST, CFG_BUS16_RST, CFG_CS_RW_RST})
		else $error("controller config not at boot default");

	COV_MEM: cover property (mem_acc ##1 !smc_in.rd_n);
	COV_IO_WRITE: cover property (io_acc && !smc_in.wr0_n);
	COV_IDE: cover property (ide_acc ##1 ide_acc);
	COV_FLASH_CMD: cover property (flash_acc && xfer_addr[CLE_BIT] && !smc_in.wr0_n);
	COV_FLASH_LEAVE: cover property (flash_acc ##1 !in_flash_space);

endmodule

//--- testbench/card_flash_far.sv
// far-side model: flash device latching commands off the steered strobes
`timescale 1ns/100ps
module card_flash_far (
	input wire logic mclk, // system clock
	input wire logic f_we_n, // flash write enable, low
	input wire logic f_cle, // command latch enable
	input wire logic f_ale, // address latch enable
	output logic [7:0] cmd_cnt // command cycles latched
);
	logic ce_n = 1'h0; // held on a general line, never released
	logic last = 1'h0;
	initial cmd_cnt = 8'h0;
	// only the flash write enable and latch enables reach the device; the read enable and the shared write pin are not connected
	// a 16 bit part would differ only in data width
	// cycle kind comes only from the latch bits set by software
	always @(posedge mclk) begin
		last <= !ce_n && !f_we_n && f_cle && !f_ale;
		if (!ce_n && !f_we_n && f_cle && !f_ale && !last)
			cmd_cnt <= cmd_cnt + 8'h1;
	end
endmodule

//--- testbench/card_nand_steer_tb.sv
// self-checking bench for the card and flash strobe steering
`timescale 1ns/100ps
module card_nand_steer_tb import card_nand_pkg::*;;
	logic mclk = 1'h0;
	logic reset = 1'h1;
	smc_sig_s static_memory_ctrl = '1;
	logic [31:0] addr = 32'h0;
	logic rd_dir = 1'h0;
	logic s0 = 1'h0;
	logic s1 = 1'h0;
	logic nb = 1'h0;
	logic [1:0] b16 = 2'h0;
	logic cfg_load = 1'h0;
	smc_cfg_s cfg_in = '0;
	pin_s pins;
	logic ce_l, ce_h, reg_o, f_oe, f_we, f_ale, f_cle;
	card_mode_e mode_o;
	smc_cfg_s cfg_o;
	logic [1:0] em = 2'h0;
	logic [7:0] cmd_cnt;
	int failures = 0;
	int n_tests = 0;

	always #10 mclk = ~mclk;

	card_nand_steer dut (.mclk(mclk), .reset(reset), .smc_in(static_memory_ctrl), .xfer_addr(addr),
		.xfer_read(rd_dir), .slot0_assign_bit(s0), .slot1_assign_bit(s1),
		.nand_assign_bit(nb), .card_bus16(b16), .cfg_load(cfg_load), .cfg_in(cfg_in),
		.pins_r(pins), .card_enable_low_r(ce_l), .card_enable_high_r(ce_h),
		.card_reg_r(reg_o), .flash_output_enable_r(f_oe), .flash_write_enable_r(f_we),
		.flash_ale_r(f_ale), .flash_cle_r(f_cle), .card_mode_r(mode_o), .smc_cfg_r(cfg_o));
	card_flash_far far (.mclk(mclk), .f_we_n(f_we), .f_cle(f_cle), .f_ale(f_ale),
		.cmd_cnt(cmd_cnt));

	// reference outputs from the steering tables, current inputs
	function automatic logic [14:0] want();
		logic ca, c0, fa;
		logic [1:0] m;
		logic [3:0] s;
		logic [1:0] ce;
		m = addr[MODE_HI:MODE_LO];
		c0 = s0 & !static_memory_ctrl.cs_n[4];
		ca = c0 | (s1 & !static_memory_ctrl.cs_n[2]);
		fa = nb & !static_memory_ctrl.cs_n[3] & (addr[SPACE_HI:SPACE_LO] == FLASH_SPACE);
		s = !ca ? {static_memory_ctrl.rd_n, static_memory_ctrl.wr0_n, static_memory_ctrl.bs1_n, static_memory_ctrl.bs3_n} :
			!m[1] ? {static_memory_ctrl.rd_n, static_memory_ctrl.wr0_n, 2'h3} : {!m[0], 1'h1, static_memory_ctrl.rd_n, static_memory_ctrl.wr0_n};
		ce = !ca ? 2'h3 : (c0 ? b16[0] : b16[1]) ? {static_memory_ctrl.lb_n, static_memory_ctrl.ub_n} : 2'h1;
		return {ca ? rd_dir : static_memory_ctrl.cs_n[0], static_memory_ctrl.cs_n[2], static_memory_ctrl.cs_n[3], static_memory_ctrl.cs_n[4], s, ce,
			addr[REG_BIT], fa ? static_memory_ctrl.rd_n : 1'h1, fa ? static_memory_ctrl.wr0_n : 1'h1,
			addr[ALE_BIT] & fa, addr[CLE_BIT] & fa};
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic done(input string name);
		$display("test %s ended", name);
	endtask

	// apply one transfer, outputs land one edge later
	task automatic step(input logic [4:0] asg, input logic [7:0] cs, input logic [5:0] s6,
		input logic [31:0] a, input logic d);
		@(posedge mclk);
		{s0, s1, nb, b16} <= asg;
		static_memory_ctrl <= {cs, s6};
		addr <= a;
		rd_dir <= d;
		@(posedge mclk);
		#1;
		if ((s0 & !cs[4]) | (s1 & !cs[2]))
			em = {a[23], ^a[23:22]};
		check({pins, ce_l, ce_h, reg_o, f_oe, f_we, f_ale, f_cle}, want(), "pins");
		check(mode_o, em, "mode");
	endtask

	task automatic do_reset();
		@(posedge mclk);
		reset <= 1'h1;
		repeat (4) @(posedge mclk);
		reset <= 1'h0;
		#1;
		em = 2'h0;
		check({pins, ce_l, ce_h, reg_o, f_oe, f_we, f_ale, f_cle}, 15'h7ffc, "rst pins");
		check(mode_o, 2'h0, "rst mode");
		check(cfg_o, {CFG_BYTE_SEL_RST, CFG_BUS16_RST, CFG_CS_RW_RST}, "rst cfg");
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// roughly 60 cycles of tests, so a hang is cut well after
	initial begin
		#20000;
		failures++;
		tally_and_finish();
	end

	// no other device on the card select pins sdram select stays off
	// card reset, interrupt and detect live on general lines, not modelled
	initial begin
		do_reset();
		for (int s = 0; s < 2; s++) begin
			for (int m = 0; m < 4; m++) begin
				for (int d = 0; d < 2; d++) begin
					// every mode, both slots, both directions
					step(s ? 5'h08 : 5'h11, s ? 8'hfb : 8'hef, d ? 6'h11 : 6'h22,
						{s ? 8'h30 : 8'h50, m[1:0], 22'h20_0000}, d[0]);
				end
			end
		end
		done("card modes");
		step(5'h18, 8'hfe, 6'h11, 32'h5000_0000, 1'h1); // other device, slots on
		step(5'h00, 8'hef, 6'h22, 32'h50c0_0000, 1'h0); // nothing assigned
		done("passthrough");
		step(5'h04, 8'hf7, 6'h22, 32'h4040_0000, 1'h0); // command write
		step(5'h04, 8'hf7, 6'h11, 32'h4020_0000, 1'h1); // address read
		step(5'h04, 8'hf7, 6'h11, 32'h5040_0000, 1'h1); // outside the space
		step(5'h00, 8'hf7, 6'h22, 32'h4040_0000, 1'h0); // flash logic off
		check(cmd_cnt, 8'h1, "flash cmds");
		done("flash");
		@(posedge mclk);
		cfg_load <= 1'h1;
		cfg_in <= 3'h2;
		@(posedge mclk);
		cfg_load <= 1'h0;
		#1;
		check(cfg_o, 3'h2, "cfg");
		do_reset();
		done("config");
		tally_and_finish();
	end
endmodule
